// ### adc_seq_pkg.sv
`default_nettype none
package adc_seq_pkg;
  // clock rates and derived conversion-clock enable
  localparam int unsigned CLK_HZ   = 50_000_000;
  localparam int unsigned CONVERSION_CLOCK_HZ  = 2_500_000;
  localparam int unsigned CONVERSION_CLOCK_DIV = CLK_HZ / CONVERSION_CLOCK_HZ;
  localparam logic [4:0]  CONVERSION_CLOCK_CNT_MAX = 5'(CONVERSION_CLOCK_DIV - 1);
  // conversion sequence figures, in divided-clock cycles; the trigger hold in conversion_clock edges
  localparam logic [5:0]  CONV_LAST   = 6'h31;  // 50 cycles, 0..49
  localparam logic [5:0]  PGA_LAST    = 6'h23;  // 36 cycles, 0..35
  localparam logic [1:0]  START_EDGES = 2'h2;   // divided_conversion_clock edges before start
  localparam logic [1:0]  TRIG_HOLD   = 2'h2;   // conversion_clock edges of debounce
  localparam logic [13:0] SAR_FIRST   = 14'h2000;
  // register indices (byte address is four times the index)
  localparam logic [4:0]  REG_RES_LO  = 5'h00;
  localparam logic [4:0]  REG_RES_HI  = 5'h01;
  localparam logic [4:0]  REG_VALID   = 5'h02;
  localparam logic [4:0]  REG_ADC_CTL = 5'h03;
  localparam logic [4:0]  REG_GAIN_MX = 5'h04;
  localparam logic [4:0]  REG_DIO_ST  = 5'h05;
  localparam logic [4:0]  REG_DIO_CTL = 5'h06;
  localparam logic [4:0]  REG_REF_OSC = 5'h07;
  localparam logic [4:0]  REG_SER_CTL = 5'h18;
  localparam logic [4:0]  REG_ID      = 5'h1F;
  // field positions
  localparam int unsigned START_BIT = 7;   // start_request_bit, regs 4/5
  localparam int unsigned BIN_BIT   = 5;   // straight binary readout
  localparam int unsigned OSCE_BIT  = 4;   // internal oscillator enable
  localparam int unsigned SE_BIT    = 3;   // channel_code single-ended
  localparam int unsigned BIDIR_BIT = 6;   // serial input line drives too
  localparam int unsigned LSBF_BIT  = 0;   // result bits lsb first
  localparam int unsigned I_DIRECT  = 7;
  localparam int unsigned I_READ    = 6;
  localparam int unsigned I_WIDE    = 5;
  // reset values; identity value is arbitrary
  localparam logic [7:0]  REG_RST   = 8'h00;
  localparam logic [7:0]  ID_VALUE  = 8'h5A;
  typedef enum logic {SER_INSTR, SER_DATA} ser_state_t;
  typedef enum logic [1:0] {CV_IDLE, CV_WAIT, CV_RUN} cv_state_t;
endpackage
`default_nettype wire

// ### adc_serial_command_sequencer.sv
// Added by the designer: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - result is 14-bit two's complement SAR
// - differential codes span -8192 to 8191
// - single-ended codes clamp to 0..8191
// - result shifts out msb or lsb first
// - conversion lasts 50 divided-clock cycles
// - first 36 cycles are amplifier phase
// - last 14 cycles resolve one bit each
// - four events start a conversion
// - trigger starts on second conversion clock edge
// - edge-select pin picks serial clock edge
// - serial input line can drive read data
// - busy pin high during conversion
// - reset pin restores power-on state
// - pin or register bit, ORed, takes effect
// - trigger edge-triggered, held two clock periods
// - instruction top bit picks direct or register
// - direct bits 6..4 give gain code
// - direct low bits give channel code
// - direct instruction stores low seven bits
// - bit 6 direction, bit 5 length
// - second byte goes to index xor one
// - direct start on second divided-clock edge
// - divide factor is 1, 2, 4 or 8
module adc_serial_command_sequencer
  import adc_seq_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        sclk_i,
  input  wire logic        cs_n_i,
  input  wire logic        edge_sel_i,
  input  wire logic        serial_input_line_i,
  output logic             serial_input_line_o,
  output logic             serial_input_line_oe_n_o,
  output logic             dout_o,
  input  wire logic        convert_i,
  input  wire logic        reset_pin_i,
  input  wire logic        internal_oscillator_pin_i,
  output logic             osc_on_o,
  input  wire logic        comparator_i,
  output logic      [13:0] dac_code_o,
  output logic      [2:0]  gain_code_o,
  output logic      [3:0]  channel_code_o,
  output logic             busy_o
);
  import adc_seq_pkg::*;

  logic        rst_all;
  logic        soft_rst_q;
  logic [7:0]  adc_ctl_q, gain_mux_q, dio_st_q, dio_ctl_q;
  logic [7:0]  ref_osc_q, ser_ctl_q;
  logic [13:0] result_q;
  logic [4:0]  conversion_clock_cnt_q;
  logic        conversion_clock_tick;
  logic [2:0]  divided_conversion_clock_cnt_q, df_max;
  logic        divided_conversion_clock_tick;
  logic [1:0]  trig_cnt_q;
  logic        trig_armed_q, trig_go;
  cv_state_t   cv_state_q;
  logic [1:0]  wait_cnt_q;
  logic [5:0]  cv_cnt_q;
  logic [13:0] sar_mask, sar_next, code_next;
  ser_state_t  ser_state_q;
  logic        sclk_q, act;
  logic [2:0]  bit_cnt_q;
  logic [7:0]  rx_q, rx_d, tx_q;
  logic [7:0]  rd_first, rd_second;
  logic        is_read_q, wide_q, second_q;
  logic [4:0]  idx_q;
  logic        direct_go, ser_wr, start_req;
  logic        wb_req, wb_wr;
  logic        wr_en;
  logic [4:0]  wr_idx;
  logic [7:0]  wr_data;

  // register read decode shared by bus and serial port
  function automatic logic [7:0] reg_read(input logic [4:0] i);
    logic [13:0] r;
    r = adc_ctl_q[BIN_BIT] ? {~result_q[13], result_q[12:0]} : result_q;
    case (i)
      REG_RES_LO:  reg_read = {r[5:0], 2'h0};
      REG_RES_HI:  reg_read = r[13:6];
      REG_ADC_CTL: reg_read = adc_ctl_q;
      REG_GAIN_MX: reg_read = {busy_o, gain_mux_q[6:0]};
      REG_DIO_ST:  reg_read = {busy_o, 3'h0, dio_st_q[3:0]};
      REG_DIO_CTL: reg_read = dio_ctl_q;
      REG_REF_OSC: reg_read = ref_osc_q;
      REG_SER_CTL: reg_read = ser_ctl_q;
      REG_ID:      reg_read = ID_VALUE;
      default:     reg_read = 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // reset: external, pin or write of the result low register
  assign rst_all = rst_i | reset_pin_i | soft_rst_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_all)
      soft_rst_q <= 1'b0;
    else
      soft_rst_q <= wr_en && (wr_idx == REG_RES_LO);
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion clock enable and divided clock enable
  assign conversion_clock_tick = (conversion_clock_cnt_q == CONVERSION_CLOCK_CNT_MAX);
  assign df_max    = 3'((4'h1 << adc_ctl_q[1:0]) - 4'h1);
  assign divided_conversion_clock_tick = conversion_clock_tick && (divided_conversion_clock_cnt_q == df_max);

  always_ff @(posedge clk_i)
  begin
    if (rst_all)
    begin
      conversion_clock_cnt_q <= 5'h00;
      divided_conversion_clock_cnt_q <= 3'h0;
    end
    else
    begin
      conversion_clock_cnt_q <= conversion_clock_tick ? 5'h00 : conversion_clock_cnt_q + 5'h01;
      // a trigger start restarts the divided clock so that the
      // conversion spans whole divided-clock periods
      if (conversion_clock_tick)
        divided_conversion_clock_cnt_q <= (divided_conversion_clock_cnt_q >= df_max ||
                       (trig_go && cv_state_q == CV_IDLE))
                      ? 3'h0 : divided_conversion_clock_cnt_q + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trigger pin debounce: rising level held two conversion clock edges;
  // the start fires on the accepting conversion clock edge itself
  assign trig_go = conversion_clock_tick && convert_i && trig_armed_q &&
                   (trig_cnt_q + 2'h1 == TRIG_HOLD);

  always_ff @(posedge clk_i)
  begin
    if (rst_all)
    begin
      trig_cnt_q   <= 2'h0;
      trig_armed_q <= 1'b0;
    end
    else if (conversion_clock_tick)
    begin
      if (!convert_i)
      begin
        trig_cnt_q   <= 2'h0;
        trig_armed_q <= 1'b1;
      end
      else if (trig_armed_q)
      begin
        trig_cnt_q <= trig_cnt_q + 2'h1;
        if (trig_go)
          trig_armed_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial port: active edge detect and instruction decode
  assign act = !cs_n_i && (edge_sel_i ? (sclk_i && !sclk_q)
                                      : (!sclk_i && sclk_q));
  assign rx_d = {rx_q[6:0], serial_input_line_i};
  assign direct_go = act && (ser_state_q == SER_INSTR) &&
                     (bit_cnt_q == 3'h7) && rx_d[I_DIRECT];
  assign ser_wr = act && (ser_state_q == SER_DATA) && !is_read_q &&
                  (bit_cnt_q == 3'h7);

  // read data for the first and the paired second byte of a transfer
  always_comb
  begin
    rd_first  = reg_read(rx_d[4:0]);
    rd_second = reg_read(idx_q ^ 5'h01);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_all)
    begin
      sclk_q      <= 1'b0;
      ser_state_q <= SER_INSTR;
      bit_cnt_q   <= 3'h0;
      rx_q        <= 8'h00;
      tx_q        <= 8'h00;
      is_read_q   <= 1'b0;
      wide_q      <= 1'b0;
      second_q    <= 1'b0;
      idx_q       <= 5'h00;
      dout_o      <= 1'b0;
    end
    else
    begin
      sclk_q <= sclk_i;
      if (cs_n_i)
      begin
        ser_state_q <= SER_INSTR;
        bit_cnt_q   <= 3'h0;
      end
      else if (act)
      begin
        rx_q      <= rx_d;
        bit_cnt_q <= bit_cnt_q + 3'h1;
        if (ser_state_q == SER_INSTR)
        begin
          if (bit_cnt_q == 3'h7 && !rx_d[I_DIRECT])
          begin
            ser_state_q <= SER_DATA;
            is_read_q   <= rx_d[I_READ];
            wide_q      <= rx_d[I_WIDE];
            second_q    <= 1'b0;
            idx_q       <= rx_d[4:0];
            tx_q        <= rd_first;
            dout_o      <= ser_ctl_q[LSBF_BIT] ? rd_first[0] : rd_first[7];
          end
        end
        else if (bit_cnt_q == 3'h7)
        begin
          if (wide_q && !second_q)
          begin
            second_q <= 1'b1;
            idx_q    <= idx_q ^ 5'h01;
            tx_q     <= rd_second;
            dout_o   <= ser_ctl_q[LSBF_BIT] ? rd_second[0] : rd_second[7];
          end
          else
            ser_state_q <= SER_INSTR;
        end
        else if (ser_ctl_q[LSBF_BIT])
        begin
          tx_q   <= {1'b0, tx_q[7:1]};
          dout_o <= tx_q[1];
        end
        else
        begin
          tx_q   <= {tx_q[6:0], 1'b0};
          dout_o <= tx_q[6];
        end
      end
    end
  end

  // serial input line turns round to drive read data when bidirectional
  always_ff @(posedge clk_i)
  begin
    if (rst_all)
    begin
      serial_input_line_o      <= 1'b0;
      serial_input_line_oe_n_o <= 1'b1;
    end
    else
    begin
      serial_input_line_o      <= dout_o;
      serial_input_line_oe_n_o <= !(ser_ctl_q[BIDIR_BIT] && !cs_n_i &&
                                    ser_state_q == SER_DATA && is_read_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write port: serial wins, bus waits a cycle on a clash
  assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o && !ser_wr && !direct_go;
  assign wb_wr   = wb_req && wb_we_i && wb_sel_i[0];
  assign wr_en   = ser_wr || wb_wr;
  assign wr_idx  = ser_wr ? idx_q : wb_adr_i[6:2];
  assign wr_data = ser_wr ? rx_d : wb_dat_i[7:0];
  assign start_req = direct_go ||
                     (wr_en && wr_data[START_BIT] &&
                      (wr_idx == REG_GAIN_MX || wr_idx == REG_DIO_ST));

  always_ff @(posedge clk_i)
  begin
    if (rst_all)
    begin
      adc_ctl_q  <= REG_RST;
      gain_mux_q <= REG_RST;
      dio_st_q   <= REG_RST;
      dio_ctl_q  <= REG_RST;
      ref_osc_q  <= REG_RST;
      ser_ctl_q  <= REG_RST;
    end
    else if (direct_go)
      gain_mux_q <= {1'b0, rx_d[6:0]};
    else if (wr_en)
    begin
      case (wr_idx)
        REG_ADC_CTL: adc_ctl_q  <= wr_data;
        REG_GAIN_MX: gain_mux_q <= {1'b0, wr_data[6:0]};
        REG_DIO_ST:  dio_st_q   <= {4'h0, wr_data[3:0]};
        REG_DIO_CTL: dio_ctl_q  <= {4'h0, wr_data[3:0]};
        REG_REF_OSC: ref_osc_q  <= wr_data;
        REG_SER_CTL: ser_ctl_q  <= wr_data;
        default:     ser_ctl_q  <= ser_ctl_q;
      endcase
    end
  end

  // wishbone answer one cycle after the request
  always_ff @(posedge clk_i)
  begin
    if (rst_all)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i)
        wb_dat_o <= {24'h00_0000, reg_read(wb_adr_i[6:2])};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // successive approximation step, offset binary trial code
  assign sar_mask  = 14'h0001 << (CONV_LAST - cv_cnt_q);
  assign sar_next  = (comparator_i ? dac_code_o : (dac_code_o & ~sar_mask))
                     | (sar_mask >> 1);
  assign code_next = {~sar_next[13], sar_next[12:0]};

  always_ff @(posedge clk_i)
  begin
    if (rst_all)
    begin
      cv_state_q <= CV_IDLE;
      wait_cnt_q <= 2'h0;
      cv_cnt_q   <= 6'h00;
      busy_o     <= 1'b0;
      dac_code_o <= 14'h0000;
      result_q   <= 14'h0000;
    end
    else
    begin
      case (cv_state_q)
        CV_IDLE:
        begin
          if (trig_go)
          begin
            cv_state_q <= CV_RUN;
            cv_cnt_q   <= 6'h00;
            busy_o     <= 1'b1;
          end
          else if (start_req)
          begin
            cv_state_q <= CV_WAIT;
            wait_cnt_q <= 2'h0;
          end
        end
        CV_WAIT:
        begin
          if (divided_conversion_clock_tick)
          begin
            wait_cnt_q <= wait_cnt_q + 2'h1;
            if (wait_cnt_q + 2'h1 == START_EDGES)
            begin
              cv_state_q <= CV_RUN;
              cv_cnt_q   <= 6'h00;
              busy_o     <= 1'b1;
            end
          end
        end
        CV_RUN:
        begin
          if (divided_conversion_clock_tick)
          begin
            cv_cnt_q <= cv_cnt_q + 6'h01;
            if (cv_cnt_q == PGA_LAST)
              dac_code_o <= SAR_FIRST;
            else if (cv_cnt_q > PGA_LAST)
              dac_code_o <= sar_next;
            if (cv_cnt_q == CONV_LAST)
            begin
              cv_state_q <= CV_IDLE;
              busy_o     <= 1'b0;
              result_q   <= (gain_mux_q[SE_BIT] && code_next[13])
                            ? 14'h0000 : code_next;
            end
          end
        end
        default: cv_state_q <= CV_IDLE;
      endcase
    end
  end

  // configuration outputs
  always_ff @(posedge clk_i)
  begin
    if (rst_all)
      osc_on_o <= 1'b0;
    else
      osc_on_o <= internal_oscillator_pin_i || ref_osc_q[OSCE_BIT];
  end
  assign gain_code_o    = gain_mux_q[6:4];
  assign channel_code_o = gain_mux_q[3:0];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_all);

  a_conv_length: assert property (
    cv_state_q == CV_RUN && divided_conversion_clock_tick && cv_cnt_q == CONV_LAST
    |=> !busy_o && cv_state_q == CV_IDLE)
    else $error("conversion did not end after 50 cycles");
  a_sar_phase: assert property (
    cv_state_q == CV_RUN && divided_conversion_clock_tick && cv_cnt_q < PGA_LAST
    |=> $stable(dac_code_o))
    else $error("trial code moved in amplifier phase");
  a_sar_seed: assert property (
    cv_state_q == CV_RUN && divided_conversion_clock_tick && cv_cnt_q == PGA_LAST
    |=> dac_code_o == SAR_FIRST)
    else $error("sar did not start at top bit");
  a_busy_run: assert property (
    busy_o == (cv_state_q == CV_RUN))
    else $error("busy does not match conversion");
  a_start_ignored: assert property (
    cv_state_q == CV_RUN && start_req |=> cv_state_q != CV_WAIT)
    else $error("start accepted while converting");
  a_direct_store: assert property (
    direct_go |=> gain_mux_q[6:0] == $past(rx_d[6:0]))
    else $error("direct instruction not stored");
  a_second_index: assert property (
    act && ser_state_q == SER_DATA && bit_cnt_q == 3'h7 && wide_q &&
    !second_q |=> idx_q == ($past(idx_q) ^ 5'h01))
    else $error("second byte index wrong");
  a_single_ended: assert property (
    cv_state_q == CV_RUN ##1 cv_state_q == CV_IDLE && gain_mux_q[SE_BIT]
    |-> !result_q[13])
    else $error("negative single-ended code");
  a_trig_start: assert property (
    cv_state_q == CV_IDLE && trig_go |=> busy_o)
    else $error("trigger did not start conversion");
  a_osc_or: assert property (
    1'b1 |=> osc_on_o == ($past(internal_oscillator_pin_i) ||
                          $past(ref_osc_q[OSCE_BIT])))
    else $error("oscillator enable not ored");
  a_wb_ack: assert property (
    wb_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle");

  c_direct: cover property (direct_go ##[1:300] busy_o);
  c_trigger: cover property (trig_go ##1 busy_o);
  c_wide_read: cover property (
    act && ser_state_q == SER_DATA && is_read_q && second_q);
endmodule // adc_serial_command_sequencer
`default_nettype wire

// ### adc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// host side of the serial port, paced off the system clock
module adc_host_model (
  input  wire logic clk_i,
  input  wire logic edge_sel_i,
  input  wire logic dout_i,
  input  wire logic line_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      sdi_o
);
  localparam int PH = 6;  // clk cycles per sclk phase

  // idle levels from time zero
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o  = 1'b0;
  end

  // one byte out msb first; each bit in is taken before the active edge
  task automatic xbyte(input logic [7:0] tx, input bit ln,
                       output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      sdi_o <= tx[i];
      repeat (PH) @(posedge clk_i);
      rx[i] = ln ? line_i : dout_i;
      sclk_o <= edge_sel_i;
      repeat (PH) @(posedge clk_i);
      sclk_o <= ~edge_sel_i;
    end
  endtask

  // instruction byte, then nb write or read bytes; clock still outside
  task automatic frame(input logic [7:0] ins, input logic [15:0] tx,
                       input int nb, input bit ln,
                       output logic [15:0] rx);
    logic [7:0] b;
    rx = 16'h0000;
    sclk_o <= ~edge_sel_i;
    repeat (PH) @(posedge clk_i);
    cs_n_o <= 1'b0;
    repeat (PH) @(posedge clk_i);
    xbyte(ins, 1'b0, b);
    for (int k = 0; k < nb; k++)
    begin
      xbyte(k ? tx[7:0] : tx[15:8], ln, b);
      rx = {rx[7:0], b};
    end
    repeat (PH) @(posedge clk_i);
    cs_n_o <= 1'b1;
    sdi_o  <= ~sdi_o;  // released line shows no stale bit
  endtask
endmodule // adc_host_model
`default_nettype wire

// ### tb_adc_serial_command_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
module tb_adc_serial_command_sequencer;
  import adc_seq_pkg::*;

  logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0;
  logic        we = 1'b0, esel = 1'b1, cv = 1'b0, rpin = 1'b0;
  logic        oscp = 1'b0, cmp = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [13:0] tgt = 14'h0000;
  wire logic [31:0] rdat;
  wire logic [13:0] dac;
  wire logic [2:0]  gain;
  wire logic [3:0]  chan;
  wire logic        ack, sclk, cs_n, sdi_h, line, ser_o, oe_n, dout;
  wire logic        osc, busy;
  int          n_fail = 0, checks_done = 0;

  // block under test and the host model
  adc_serial_command_sequencer i_adc_serial_command_sequencer (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .sclk_i(sclk), .cs_n_i(cs_n),
    .edge_sel_i(esel), .serial_input_line_i(line),
    .serial_input_line_o(ser_o), .serial_input_line_oe_n_o(oe_n),
    .dout_o(dout), .convert_i(cv), .reset_pin_i(rpin),
    .internal_oscillator_pin_i(oscp), .osc_on_o(osc),
    .comparator_i(cmp), .dac_code_o(dac), .gain_code_o(gain),
    .channel_code_o(chan), .busy_o(busy));
  adc_host_model i_adc_host_model (
    .clk_i(clk), .edge_sel_i(esel), .dout_i(dout), .line_i(line),
    .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi_h));

  // clock, shared serial line, ideal comparator
  always #10 clk = ~clk;
  assign line = oe_n ? sdi_h : ser_o;
  always @(posedge clk) cmp <= (tgt >= dac);

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one classic bus cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [4:0] idx,
                     input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {1'b0, idx, 2'b00};
    dat <= {24'h0, wd};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1);
    chk({15'h0, (n <= 3)}, 16'h0001);
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [4:0] idx, input logic [7:0] wd);
    logic [7:0] x;
    bus(1'b1, idx, wd, x);
  endtask

  task automatic rd(input logic [4:0] idx, output logic [7:0] d);
    bus(1'b0, idx, 8'h00, d);
  endtask

  // time busy, then read the result once it is low
  task automatic conv_chk(input int w_exp, input bit se);
    int          n;
    int          w;
    logic [7:0]  hi;
    logic [7:0]  lo;
    logic [13:0] r;
    n = 0;
    w = 0;
    while (busy !== 1'b1 && n < 1000)
    begin
      @(posedge clk);
      n++;
    end
    while (busy === 1'b1 && w < 20000)
    begin
      @(posedge clk);
      w++;
    end
    chk(16'(w), 16'(w_exp));
    r = (se && !tgt[13]) ? 14'h0000 : {~tgt[13], tgt[12:0]};
    rd(REG_RES_HI, hi);
    rd(REG_RES_LO, lo);
    chk({hi, lo}, {r, 2'b00});
  endtask

  task automatic pulse(input int n);
    cv <= 1'b1;
    repeat (n) @(posedge clk);
    cv <= 1'b0;
    @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_power_on;
    logic [7:0] d;
    chk({6'h0, busy, oe_n, osc, gain, chan}, 16'h0100);
    rd(REG_ID, d);
    chk({8'h0, d}, {8'h0, ID_VALUE});
    rd(5'h09, d);
    chk({8'h0, d}, 16'h0000);
    rd(REG_GAIN_MX, d);
    chk({8'h0, d}, 16'h0000);
    $display("test power_on done");
  endtask

  // every gain code, differential ends of scale, then single-ended
  task automatic t_direct;
    logic [7:0]  ins;
    logic [7:0]  d;
    logic [15:0] rx;
    for (int k = 0; k < 10; k++)
    begin
      ins = (k < 8) ? {1'b1, 3'(k), 4'(k)} : 8'h8C;
      tgt = (k == 8) ? 14'h1000 : (k % 2 && k > 6) ? 14'h3FFF
          : 14'(k * 'h925);
      i_adc_host_model.frame(ins, 16'h0000, 0, 1'b0, rx);
      chk({15'h0, busy}, 16'h0000);
      conv_chk(50 * CONVERSION_CLOCK_DIV, k > 7);
      chk({9'h0, gain, chan}, {9'h0, ins[6:0]});
      rd(REG_GAIN_MX, d);
      chk({8'h0, d}, {9'h0, ins[6:0]});
    end
    $display("test direct done");
  endtask

  // each divide factor, started from register 4 or 5
  task automatic t_divide;
    for (int d = 0; d < 4; d++)
    begin
      tgt = 14'(14'h1000 + d);
      wr(REG_ADC_CTL, 8'(d));
      wr(d % 2 ? REG_DIO_ST : REG_GAIN_MX, 8'h80);
      conv_chk((50 * CONVERSION_CLOCK_DIV) << d, 1'b0);
    end
    wr(REG_ADC_CTL, 8'h00);
    $display("test divide done");
  endtask

  // glitch refused, held pin starts, starts during busy ignored
  task automatic t_trigger;
    logic [15:0] rx;
    tgt = 14'h0F0F;
    pulse(1);
    repeat (100) @(posedge clk);
    chk({15'h0, busy}, 16'h0000);
    fork
      conv_chk(50 * CONVERSION_CLOCK_DIV, 1'b0);
      begin
        pulse(2 * CONVERSION_CLOCK_DIV + 2);
        repeat (200) @(posedge clk);
        pulse(2 * CONVERSION_CLOCK_DIV + 2);
        i_adc_host_model.frame(8'hF0, 16'h0000, 0, 1'b0, rx);
      end
    join
    repeat (300) @(posedge clk);
    chk({15'h0, busy}, 16'h0000);
    $display("test trigger done");
  endtask

  // serial register write and reads in every readout form
  task automatic t_serial;
    logic [15:0] rx;
    logic [7:0]  d;
    tgt = 14'h2ABC;
    i_adc_host_model.frame(8'h04, 16'hB500, 1, 1'b0, rx);
    conv_chk(50 * CONVERSION_CLOCK_DIV, 1'b0);
    chk({9'h0, gain, chan}, 16'h0035);
    i_adc_host_model.frame(8'h61, 16'h0000, 2, 1'b0, rx);
    chk(rx, 16'h2AF0);
    i_adc_host_model.frame(8'h60, 16'h0000, 2, 1'b0, rx);
    chk(rx, 16'hF02A);
    wr(REG_ADC_CTL, 8'h20);
    rd(REG_RES_HI, d);
    chk({8'h0, d}, 16'h00AA);
    wr(REG_ADC_CTL, 8'h00);
    wr(REG_SER_CTL, 8'h01);
    i_adc_host_model.frame(8'h41, 16'h0000, 1, 1'b0, rx);
    chk(rx, 16'h0054);
    wr(REG_SER_CTL, 8'h40);
    i_adc_host_model.frame(8'h41, 16'hD500, 1, 1'b1, rx);
    chk(rx, 16'h002A);
    chk({15'h0, oe_n}, 16'h0001);
    wr(REG_SER_CTL, 8'h00);
    esel <= 1'b0;
    @(posedge clk);
    i_adc_host_model.frame(8'h61, 16'h0000, 2, 1'b0, rx);
    chk(rx, 16'h2AF0);
    esel <= 1'b1;
    @(posedge clk);
    $display("test serial done");
  endtask

  // reset pin mid-conversion, oscillator OR, soft reset
  task automatic t_resets;
    logic [7:0] d;
    wr(REG_GAIN_MX, 8'hC7);
    repeat (100) @(posedge clk);
    chk({15'h0, busy}, 16'h0001);
    rpin <= 1'b1;
    @(posedge clk);
    rpin <= 1'b0;
    repeat (2) @(posedge clk);
    chk({8'h0, busy, gain, chan}, 16'h0000);
    oscp <= 1'b1;
    repeat (3) @(posedge clk);
    chk({15'h0, osc}, 16'h0001);
    oscp <= 1'b0;
    repeat (3) @(posedge clk);
    chk({15'h0, osc}, 16'h0000);
    wr(REG_REF_OSC, 8'h10);
    repeat (2) @(posedge clk);
    chk({15'h0, osc}, 16'h0001);
    wr(REG_RES_LO, 8'h00);
    repeat (3) @(posedge clk);
    rd(REG_REF_OSC, d);
    chk({7'h0, osc, d}, 16'h0000);
    $display("test resets done");
  endtask

  task automatic conclude;
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // reset, then the scenarios in turn
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_power_on();
    t_direct();
    t_divide();
    t_trigger();
    t_serial();
    t_resets();
    conclude();
  end

  // watchdog: the scenarios need about 31000 cycles
  initial
  begin
    repeat (100000) @(posedge clk);
    n_fail++;
    $display("wrong value at %0t: watchdog expired", $time);
    conclude();
  end
endmodule // tb_adc_serial_command_sequencer
`default_nettype wire
